// ### include/pst_pkg.sv
// Package of constants and types for the power supply management bus target
// What this block does
// - Run at full 100 kbps bus rate
// - Avoid holding clock low to stretch
// - Stretch under 25 ms per message
// - Clock low over 25 ms aborts, releases bus
// - Ready for new transaction 10 ms later
// - Detect START and STOP mid-byte too
// - Glitches and runt pulses never lock up
// - Resume once properly timed signals return
// - Realign bit tracking at next START/STOP
// - 256 by 8 identification store, bus readable
// - Straps select command address B0..B6
// - Straps select store address A0..A6
package pst_pkg;

    // ==========================================================
    // Addresses and store
    localparam logic [7:0] CMD_ADDR_BASE = 8'hb0;
    localparam logic [7:0] FRU_ADDR_BASE = 8'ha0;
    localparam int unsigned FRU_DEPTH = 256;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned T_TIMEOUT_US = 25000;
    localparam int unsigned T_HOLDOFF_US = 10000;
    localparam int unsigned TIMEOUT_CYC = T_TIMEOUT_US * CLK_MHZ;
    localparam int unsigned HOLDOFF_CYC = T_HOLDOFF_US * CLK_MHZ;
    localparam int unsigned CNT_W = 20;
    localparam logic [1:0] FILT_LAST = 2'h2;
    localparam logic [3:0] BITS_LAST = 4'h8;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        PST_IDLE = 3'b000,
        PST_ADDR = 3'b001,
        PST_ACKA = 3'b010,
        PST_RX = 3'b011,
        PST_ACKD = 3'b100,
        PST_TX = 3'b101,
        PST_MACK = 3'b110,
        PST_HOLD = 3'b111
    } pst_state_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } pst_cmd_rx_t;

endpackage

// ### testbench/pst_host.sv
// Behavioural host bus master driving the bus clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module pst_host (
    output logic scl,
    output logic sdaDrv,
    input wire logic sdaLine
);
    // ==========================================================
    // Bus cycles; sdaDrv high releases the line to its pull-up
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // Low phase is 320 ns: the target drives data six clocks after our fall,
    // and that change must pass its filter before it sees our next rise,
    // or it would take its own data edge for a START or STOP
    task automatic bitx(input logic b, output logic r);
        #80 sdaDrv <= b;
        #240 scl <= 1'b1;
        // Sample late: the target answers a filter delay after our fall
        #150 r = sdaLine;
        #10 scl <= 1'b0;
    endtask
    task automatic start();
        #80 sdaDrv <= 1'b1;
        #240 scl <= 1'b1;
        #240 sdaDrv <= 1'b0;
        #240 scl <= 1'b0;
    endtask
    task automatic stop();
        #80 sdaDrv <= 1'b0;
        #240 scl <= 1'b1;
        #240 sdaDrv <= 1'b1;
        #240;
    endtask
    task automatic wbits(input logic [7:0] d, input int n);
        logic r;
        for (int i = 7; i > 7 - n; i--) begin
            bitx(d[i], r);
        end
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        wbits(d, 8);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(last, r);
    endtask
    // One-cycle clock pulse, narrower than the target's filter
    task automatic runt();
        #80 scl <= 1'b1;
        #40 scl <= 1'b0;
        #40;
    endtask
    task automatic holdLow(input int ns);
        #80 scl <= 1'b0;
        #(ns) sdaDrv <= 1'b1;
        #80 scl <= 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

// ### testbench/pst_smbus_target_tb_top.sv
// Self-checking bench for the management bus target
`timescale 1ns/1ps
`default_nettype none
module pst_smbus_target_tb_top;
    import pst_pkg::*;
    // ==========================================================
    // Design, host model and pulled-up data wire
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hi = 1'b0;
    logic lo = 1'b0;
    logic [7:0] rdData = 8'h00;
    logic scl, sdaDrv, sdaOut, sdaOe, cmdReadReq, busTimeout, a;
    logic [7:0] d, firstRx, lastRx;
    pst_cmd_rx_t cmdRx;
    wire logic sdaIn = sdaDrv & ~sdaOe;
    int nFail = 0;
    int checks = 0;
    int nRx = 0;
    int nReq = 0;
    int nTo = 0;
    always #20 clk = ~clk;
    pst_smbus_target #(.TIMEOUT_CYC(200), .HOLDOFF_CYC(100)) pst_smbus_target_i (.clk(clk), .rst_n(rst_n),
        .sclIn(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .slotAddrBitHigh(hi),
        .slotAddrBitLow(lo), .cmdRx(cmdRx), .cmdReadReq(cmdReadReq), .cmdReadData(rdData),
        .busTimeout(busTimeout));
    pst_host pst_host_i (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaIn));
    always @(posedge clk) begin
        if (cmdRx.valid === 1'b1) begin
            nRx++;
            lastRx = cmdRx.data;
            if (cmdRx.first === 1'b1) begin
                firstRx = cmdRx.data;
            end
        end
        if (cmdReadReq === 1'b1) begin
            nReq++;
        end
        if (busTimeout === 1'b1) begin
            nTo++;
        end
    end
    // ==========================================================
    // Shared helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic probe(input logic [7:0] ad, input logic exp);
        pst_host_i.start();
        pst_host_i.wbyte(ad, a);
        pst_host_i.stop();
        check(16'(a), 16'(exp));
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_addr();
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            hi <= s[1];
            lo <= s[0];
            repeat (4) @(posedge clk);
            probe(8'hb0 + 8'(2 * s), 1'b1);
            probe(8'ha0 + 8'(2 * s), 1'b1);
            probe(8'hb0 + 8'(2 * ((s + 1) % 4)), 1'b0);
            probe(8'ha8, 1'b0);
        end
        $display("t_addr done");
    endtask
    task automatic t_store();
        pst_host_i.start();
        pst_host_i.wbyte(8'ha6, a);
        pst_host_i.wbyte(8'hff, a);
        pst_host_i.wbyte(8'h5a, a);
        pst_host_i.wbyte(8'hc3, a);
        pst_host_i.stop();
        check(16'(a), 16'h1);
        pst_host_i.start();
        pst_host_i.wbyte(8'ha6, a);
        pst_host_i.wbyte(8'hff, a);
        pst_host_i.start();
        pst_host_i.wbyte(8'ha7, a);
        pst_host_i.rbyte(1'b0, d);
        check(16'(d), 16'h5a);
        pst_host_i.rbyte(1'b1, d);
        pst_host_i.stop();
        check(16'(d), 16'hc3);
        $display("t_store done");
    endtask
    task automatic t_cmd();
        int n = nRx;
        int r = nReq;
        pst_host_i.start();
        pst_host_i.wbyte(8'hb6, a);
        pst_host_i.wbyte(8'h3c, a);
        pst_host_i.wbyte(8'h7e, a);
        pst_host_i.stop();
        check(16'(nRx - n), 16'h2);
        check(16'(firstRx), 16'h3c);
        check(16'(lastRx), 16'h7e);
        @(posedge clk);
        rdData <= 8'h96;
        pst_host_i.start();
        pst_host_i.wbyte(8'hb7, a);
        pst_host_i.rbyte(1'b1, d);
        pst_host_i.stop();
        check(16'(d), 16'h96);
        check(16'(nReq - r), 16'h1);
        $display("t_cmd done");
    endtask
    task automatic t_mid();
        int n = nRx;
        pst_host_i.start();
        pst_host_i.wbyte(8'hb6, a);
        pst_host_i.wbits(8'hff, 3);
        pst_host_i.stop();
        check(16'(nRx - n), 16'h0);
        probe(8'hb6, 1'b1);
        pst_host_i.start();
        pst_host_i.wbits(8'h00, 5);
        pst_host_i.start();
        pst_host_i.wbyte(8'ha6, a);
        pst_host_i.stop();
        check(16'(a), 16'h1);
        $display("t_mid done");
    endtask
    task automatic t_glitch();
        pst_host_i.start();
        pst_host_i.wbits(8'hb6, 4);
        pst_host_i.runt();
        pst_host_i.runt();
        pst_host_i.wbits(8'h60, 4);
        pst_host_i.bitx(1'b1, a);
        check(16'(a), 16'h0);
        pst_host_i.stop();
        probe(8'ha6, 1'b1);
        $display("t_glitch done");
    endtask
    task automatic t_timeout();
        int t = nTo;
        pst_host_i.holdLow(180 * 40);
        check(16'(nTo - t), 16'h0);
        // Park in the ack slot so the target is pulling data low
        pst_host_i.start();
        pst_host_i.wbits(8'ha6, 8);
        pst_host_i.holdLow(260 * 40);
        check(16'(nTo - t), 16'h1);
        check(16'(sdaOe), 16'h0);
        check(16'(sdaOut), 16'h0);
        repeat (110) @(posedge clk);
        probe(8'ha6, 1'b1);
        $display("t_timeout done");
    endtask
    // ==========================================================
    // Sequence and watchdog
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk);
        t_addr();
        t_store();
        t_cmd();
        t_mid();
        t_glitch();
        t_timeout();
        close_out();
    end
    // The tests need roughly 0.23 ms; over four times that means a hang
    initial begin
        #1000000;
        nFail++;
        close_out();
    end
endmodule
`default_nettype wire

// ### verilog/pst_smbus_target.sv
// Management bus target with identification store, timeout and bus recovery
`timescale 1ns/1ps
`default_nettype none
module pst_smbus_target #(
    parameter int unsigned TIMEOUT_CYC = pst_pkg::TIMEOUT_CYC,
    parameter int unsigned HOLDOFF_CYC = pst_pkg::HOLDOFF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic slotAddrBitHigh,
    input wire logic slotAddrBitLow,
    output pst_pkg::pst_cmd_rx_t cmdRx,
    output logic cmdReadReq,
    input wire logic [7:0] cmdReadData,
    output logic busTimeout
);
    import pst_pkg::*;

    localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLDOFF_CYC - 1);

    // ==========================================================
    // Pin synchronisers and glitch filters (bit 1 = clock, bit 0 = data)
    logic [1:0] pinS1_ff, pinS2_ff, pinF_ff, pinP_ff;
    logic [1:0] strapS1_ff, strapS2_ff;
    logic [1:0] fltCnt_ff [2];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinS1_ff <= 2'h3;
            pinS2_ff <= 2'h3;
            pinP_ff <= 2'h3;
            strapS1_ff <= 2'h0;
            strapS2_ff <= 2'h0;
        end else begin
            pinS1_ff <= {sclIn, sdaIn};
            pinS2_ff <= pinS1_ff;
            pinP_ff <= pinF_ff;
            strapS1_ff <= {slotAddrBitHigh, slotAddrBitLow};
            strapS2_ff <= strapS1_ff;
        end
    end

    // A level must hold three samples before it counts, so runt pulses vanish
    for (genvar i = 0; i < 2; i++) begin : g_flt
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                fltCnt_ff[i] <= 2'h0;
                pinF_ff[i] <= 1'b1;
            end else if (pinS2_ff[i] == pinF_ff[i]) begin
                fltCnt_ff[i] <= 2'h0;
            end else if (fltCnt_ff[i] == FILT_LAST) begin
                fltCnt_ff[i] <= 2'h0;
                pinF_ff[i] <= pinS2_ff[i];
            end else begin
                fltCnt_ff[i] <= fltCnt_ff[i] + 2'h1;
            end
        end
    end

    wire sclHigh = pinF_ff[1];
    wire sdaBit = pinF_ff[0];
    wire sclRise = pinF_ff[1] & ~pinP_ff[1];
    wire sclFall = ~pinF_ff[1] & pinP_ff[1];
    // Checked every cycle, not just at byte ends
    wire startCond = pinF_ff[1] & pinP_ff[1] & pinP_ff[0] & ~pinF_ff[0];
    wire stopCond = pinF_ff[1] & pinP_ff[1] & ~pinP_ff[0] & pinF_ff[0];

    // ==========================================================
    // Address selection from the straps
    wire [7:0] cmdAddr = CMD_ADDR_BASE | {5'h0, strapS2_ff, 1'b0};
    wire [7:0] fruAddr = FRU_ADDR_BASE | {5'h0, strapS2_ff, 1'b0};

    // ==========================================================
    // Transfer state
    pst_state_t state_ff;
    logic [3:0] bitCnt_ff;
    logic [7:0] rxSh_ff, txSh_ff, ptr_ff;
    logic isFru_ff, rw_ff, firstByte_ff, mAck_ff, sdaOe_ff;
    logic [CNT_W-1:0] sclLow_ff, hold_ff;
    pst_cmd_rx_t cmdRx_ff;
    logic cmdReadReq_ff, busTimeout_ff;
    logic [7:0] fruMem [FRU_DEPTH];

    wire matchCmd = (rxSh_ff[7:1] == cmdAddr[7:1]);
    wire matchFru = (rxSh_ff[7:1] == fruAddr[7:1]);
    wire byteDone = sclFall & (bitCnt_ff == BITS_LAST);
    wire timeoutHit = ~sclHigh & (sclLow_ff == TO_LAST) & (state_ff != PST_HOLD);
    wire holdDone = (state_ff == PST_HOLD) & (hold_ff == HOLD_LAST);
    wire loadTx = sclFall & (((state_ff == PST_ACKA) & rw_ff) | ((state_ff == PST_MACK) & mAck_ff));
    wire [7:0] txByte = isFru_ff ? fruMem[ptr_ff] : cmdReadData;
    wire fruWe = (state_ff == PST_RX) & byteDone & isFru_ff & ~firstByte_ff & ~startCond & ~stopCond;

    // The store has no reset; its contents are whatever was written over the bus
    always_ff @(posedge clk) begin
        if (fruWe) begin
            fruMem[ptr_ff] <= rxSh_ff;
        end
    end

    // Clock-low watchdog; it counts in every state and fires in every state but PST_HOLD, so a stuck bus can never hang us
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclLow_ff <= '0;
            hold_ff <= '0;
        end else begin
            sclLow_ff <= (sclHigh || timeoutHit) ? '0 : sclLow_ff + 1'b1;
            hold_ff <= (state_ff == PST_HOLD) ? hold_ff + 1'b1 : '0;
        end
    end

    // Target never drives the clock, so it never stretches and the
    // per-message stretch budget is always zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= PST_IDLE;
            bitCnt_ff <= 4'h0;
            rxSh_ff <= 8'h00;
            txSh_ff <= 8'h00;
            ptr_ff <= 8'h00;
            isFru_ff <= 1'b0;
            rw_ff <= 1'b0;
            firstByte_ff <= 1'b0;
            mAck_ff <= 1'b0;
            sdaOe_ff <= 1'b0;
            cmdRx_ff <= '0;
            cmdReadReq_ff <= 1'b0;
            busTimeout_ff <= 1'b0;
        end else begin
            cmdRx_ff.valid <= 1'b0;
            cmdReadReq_ff <= 1'b0;
            busTimeout_ff <= timeoutHit;
            if (timeoutHit) begin
                state_ff <= PST_HOLD;
                sdaOe_ff <= 1'b0;
            end else if (state_ff == PST_HOLD) begin
                if (holdDone) begin
                    state_ff <= PST_IDLE;
                end
            end else if (stopCond) begin
                state_ff <= PST_IDLE;
                sdaOe_ff <= 1'b0;
            end else if (startCond) begin
                state_ff <= PST_ADDR;
                bitCnt_ff <= 4'h0;
                sdaOe_ff <= 1'b0;
            end else if (loadTx) begin
                state_ff <= PST_TX;
                bitCnt_ff <= 4'h0;
                txSh_ff <= txByte;
                sdaOe_ff <= ~txByte[7];
                ptr_ff <= isFru_ff ? ptr_ff + 8'h01 : ptr_ff;
                cmdReadReq_ff <= ~isFru_ff;
            end else begin
                case (state_ff)
                    PST_IDLE: begin
                        sdaOe_ff <= 1'b0;
                    end
                    PST_ADDR, PST_RX: begin
                        if (sclRise && bitCnt_ff != BITS_LAST) begin
                            rxSh_ff <= {rxSh_ff[6:0], sdaBit};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end else if (byteDone && state_ff == PST_ADDR) begin
                            // Other addresses get no acknowledge
                            sdaOe_ff <= matchCmd | matchFru;
                            state_ff <= (matchCmd | matchFru) ? PST_ACKA : PST_IDLE;
                            isFru_ff <= matchFru;
                            rw_ff <= rxSh_ff[0];
                        end else if (byteDone) begin
                            sdaOe_ff <= 1'b1;
                            state_ff <= PST_ACKD;
                            firstByte_ff <= 1'b0;
                            if (isFru_ff) begin
                                ptr_ff <= firstByte_ff ? rxSh_ff : ptr_ff + 8'h01;
                            end else begin
                                cmdRx_ff <= '{valid: 1'b1, first: firstByte_ff, data: rxSh_ff};
                            end
                        end
                    end
                    PST_ACKA, PST_ACKD: begin
                        if (sclFall) begin
                            sdaOe_ff <= 1'b0;
                            bitCnt_ff <= 4'h0;
                            state_ff <= PST_RX;
                            firstByte_ff <= (state_ff == PST_ACKA) ? 1'b1 : firstByte_ff;
                        end
                    end
                    PST_TX: begin
                        if (sclRise) begin
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end else if (byteDone) begin
                            sdaOe_ff <= 1'b0;
                            state_ff <= PST_MACK;
                        end else if (sclFall) begin
                            txSh_ff <= {txSh_ff[6:0], 1'b0};
                            sdaOe_ff <= ~txSh_ff[6];
                        end
                    end
                    PST_MACK: begin
                        if (sclRise) begin
                            mAck_ff <= ~sdaBit;
                        end else if (sclFall) begin
                            state_ff <= PST_IDLE;
                        end
                    end
                    default: begin
                        state_ff <= PST_IDLE;
                        sdaOe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_ff;
    assign cmdRx = cmdRx_ff;
    assign cmdReadReq = cmdReadReq_ff;
    assign busTimeout = busTimeout_ff;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cmd_addr;
        cmdAddr == {5'h16, strapS2_ff, 1'b0};
    endproperty
    a_cmd_addr: assert property (p_cmd_addr) else $error("command address mismatch");

    property p_fru_addr;
        fruAddr == {5'h14, strapS2_ff, 1'b0};
    endproperty
    a_fru_addr: assert property (p_fru_addr) else $error("store address mismatch");

    property p_timeout;
        timeoutHit |=> state_ff == PST_HOLD && !sdaOe_ff && busTimeout_ff;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not abort");

    property p_holdoff;
        (state_ff == PST_HOLD) && holdDone |=> state_ff == PST_IDLE;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("holdoff did not end");

    property p_start;
        startCond && !timeoutHit && state_ff != PST_HOLD |=> state_ff == PST_ADDR && bitCnt_ff == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        stopCond && !timeoutHit && state_ff != PST_HOLD |=> state_ff == PST_IDLE ##1 !sdaOe_ff;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");

    property p_nack;
        state_ff == PST_ADDR && byteDone && !startCond && !stopCond && !timeoutHit
            && !matchCmd && !matchFru |=> !sdaOe_ff && state_ff == PST_IDLE;
    endproperty
    a_nack: assert property (p_nack) else $error("foreign address acknowledged");

    property p_filter;
        (pinS2_ff[1] == 1'b0)[*4] |=> !pinF_ff[1];
    endproperty
    a_filter: assert property (p_filter) else $error("filter stuck");

    property p_idle_quiet;
        state_ff == PST_IDLE |=> !sdaOe_ff || state_ff != PST_IDLE;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("driving data while idle");

    property p_store_ptr;
        fruWe |=> ptr_ff == $past(ptr_ff) + 8'h01;
    endproperty
    a_store_ptr: assert property (p_store_ptr) else $error("store pointer not advanced");

    c_addr_ack: cover property (state_ff == PST_ADDR ##[1:400] state_ff == PST_ACKA);
    c_tx: cover property (state_ff == PST_TX ##[1:1000] state_ff == PST_MACK);
    c_timeout: cover property (timeoutHit);
    c_cmd_rx: cover property (cmdRx_ff.valid);

endmodule
`default_nettype wire
